/* design/io_ports_regs.vh */
`ifndef IO_PORTS_REGS_VH
`define IO_PORTS_REGS_VH
// Register indices, one aligned word each
`define ANALOG_PORT_DATA_IDX 12'h005
`define LED_PORT_DATA_IDX 12'h006
`define ANALOG_PORT_DIR_IDX 12'h085
`define LED_PORT_DIR_IDX 12'h086
`define CONV_CFG_ONE_IDX 12'h09f
`define OPTION_IDX 12'h081
`define IRQ_FLAG_IDX 12'h00c
`define IRQ_ENABLE_IDX 12'h08c
`define CHARGE_CFG_IDX 12'h0a0
`define TWOWIRE_CTRL_IDX 12'h014
// Byte addresses, four times the index
`define ANALOG_PORT_DATA_ADDR 12'h014
`define LED_PORT_DATA_ADDR 12'h018
`define ANALOG_PORT_DIR_ADDR 12'h214
`define LED_PORT_DIR_ADDR 12'h218
`define CONV_CFG_ONE_ADDR 12'h27c
`define OPTION_ADDR 12'h204
`define IRQ_FLAG_ADDR 12'h030
`define IRQ_ENABLE_ADDR 12'h230
`define CHARGE_CFG_ADDR 12'h280
`define TWOWIRE_CTRL_ADDR 12'h050
// Field positions
`define PULLUP_DIS_BIT 7
`define CHANGE_FLAG_BIT 0
`define CHANGE_EN_BIT 3
`define CHARGE_EN_BIT 1
`define TWOWIRE_EN_BIT 5
`define ANALOG_SEL_LSB 0
`define ANALOG_SEL_MSB 1
// Reset values
`define DIR_RESET 8'hff
`define OPTION_RESET 8'hff
`define CONV_CFG_RESET 8'h00
`define ZERO_BYTE 8'h00
`define ZERO_WORD 32'h0000_0000
`endif

/* design/pin_sync.v */
`timescale 1ns/100ps
`default_nettype none
// Two-stage synchroniser for a bank of pin inputs
module pin_sync #(
	parameter WIDTH = 8
) (
	input wire clk,
	input wire rst_n,
	input wire ce,
	input wire [WIDTH-1:0] pin_in,
	output wire [WIDTH-1:0] pin_sync_out
);
	reg [WIDTH-1:0] stage1_ff; // First stage, read only by second
	reg [WIDTH-1:0] stage2_ff; // Second stage
	// Shift pins through two flops
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			stage1_ff <= {WIDTH{1'b0}};
			stage2_ff <= {WIDTH{1'b0}};
		end
		else if (ce)
		begin
			stage1_ff <= pin_in;
			stage2_ff <= stage1_ff;
		end
	end
	assign pin_sync_out = stage2_ff;
endmodule
`default_nettype wire

/* design/change_detect.v */
`timescale 1ns/100ps
`default_nettype none
// Interrupt-on-change comparison for the upper LED port pins
module change_detect #(
	parameter WIDTH = 4
) (
	input wire clk,
	input wire rst_n,
	input wire ce,
	input wire [WIDTH-1:0] pins,
	input wire [WIDTH-1:0] monitor_en,
	input wire snapshot,
	output wire mismatch
);
	reg [WIDTH-1:0] old_ff; // Value latched at last port read
	// Latch pin levels on each port read
	always @(posedge clk)
	begin
		if (!rst_n)
			old_ff <= {WIDTH{1'b0}};
		else if (ce && snapshot)
			old_ff <= pins;
	end
	// Mismatches of monitored inputs ORed
	assign mismatch = |((pins ^ old_ff) & monitor_en);
endmodule
`default_nettype wire

/* design/mixed_signal_io_ports.v */
// The implementer's own choice: register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "io_ports_regs.vh"
module mixed_signal_io_ports #(
	parameter APORT_W = 4,
	parameter LPORT_W = 8
) (
	input wire clk,
	input wire rst_n,
	input wire ce,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [APORT_W-1:0] analog_pin_in,
	output reg [APORT_W-1:0] analog_pin_out,
	output reg [APORT_W-1:0] analog_pin_oe,
	output reg [APORT_W-1:0] analog_sel_out,
	input wire [LPORT_W-1:0] led_pin_in,
	output reg [LPORT_W-1:0] led_pin_out,
	output reg [LPORT_W-1:0] led_pin_oe,
	output reg [5:0] led_pullup_en,
	input wire twowire_sda_out,
	input wire twowire_sda_oe,
	input wire twowire_scl_out,
	input wire twowire_scl_oe,
	input wire charge_dac_out,
	input wire charge_cmp_out,
	output reg charge_dac_sel,
	output reg change_irq,
	output reg change_wake
);
	// Software-visible registers
	reg [APORT_W-1:0] analog_latch_ff; // Analog port output latch
	reg [APORT_W-1:0] analog_dir_ff; // Analog port direction, 1 = input
	reg [LPORT_W-1:0] led_latch_ff; // LED port output latch
	reg [LPORT_W-1:0] led_dir_ff; // LED port direction, 1 = input
	reg [7:0] conv_cfg_ff; // Converter config one
	reg [7:0] option_ff; // Option register
	reg [7:0] irq_en_ff; // Interrupt enable register
	reg [7:0] charge_cfg_ff; // Charge config register
	reg [7:0] twowire_ctrl_ff; // Two-wire control register
	reg change_flag_ff; // Sticky change flag
	reg [31:0] nxt_prdata; // Read mux
	reg nxt_slverr; // Unmapped address
	reg [APORT_W-1:0] analog_mask; // 1 = pin in analog mode
	reg [APORT_W-1:0] nxt_analog_out; // Analog pin drive
	reg [APORT_W-1:0] nxt_analog_oe; // Analog pin enable
	reg [LPORT_W-1:0] nxt_led_out; // LED pin drive
	reg [LPORT_W-1:0] nxt_led_oe; // LED pin enable
	reg [5:0] nxt_pullup; // Pull-up enables
	reg [3:0] monitor_en; // Change compare enables
	reg nxt_flag; // Next change flag
	wire [APORT_W-1:0] analog_sync; // Synchronised analog pins
	wire [LPORT_W-1:0] led_sync; // Synchronised LED pins
	wire [APORT_W-1:0] analog_digital_in; // Gated digital path
	wire mismatch; // Change detect result
	wire access; // APB access phase
	wire wr; // Write strobe
	wire rd; // Read strobe
	wire twowire_en; // Two-wire module enabled
	wire charge_en; // Charge control enabled
	wire led_read; // Read of LED port data
	wire flag_wr_clear; // Software clears the flag

	// Which analog pins are analog, from the select field
	function [3:0] analog_decode;
		input [1:0] sel;
		begin
			case (sel)
				2'b00: analog_decode = 4'hf;
				2'b01: analog_decode = 4'h7;
				2'b10: analog_decode = 4'h3;
				default: analog_decode = 4'h0;
			endcase
		end
	endfunction

	// Zero-extend a byte for the read bus
	function [31:0] byte_word;
		input [7:0] b;
		begin
			byte_word = {24'h00_0000, b};
		end
	endfunction

	// Synchronise pin inputs
	pin_sync #(
		.WIDTH(APORT_W)
	) u_analog_sync (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.pin_in(analog_pin_in),
		.pin_sync_out(analog_sync)
	);
	pin_sync #(
		.WIDTH(LPORT_W)
	) u_led_sync (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.pin_in(led_pin_in),
		.pin_sync_out(led_sync)
	);

	assign access = psel && penable;
	assign wr = access && pwrite && pstrb[0];
	assign rd = access && !pwrite;
	assign twowire_en = twowire_ctrl_ff[`TWOWIRE_EN_BIT];
	assign charge_en = charge_cfg_ff[`CHARGE_EN_BIT];
	assign led_read = rd && (paddr == `LED_PORT_DATA_ADDR);
	assign flag_wr_clear = wr && (paddr == `IRQ_FLAG_ADDR) && !pwdata[`CHANGE_FLAG_BIT];
	// Digital input gate closed in analog mode
	assign analog_digital_in = analog_sync & ~analog_mask;

	// Interrupt-on-change comparator
	change_detect #(
		.WIDTH(4)
	) u_change (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.pins(led_sync[7:4]),
		.monitor_en(monitor_en),
		.snapshot(led_read),
		.mismatch(mismatch)
	);

	// Pin control and mode decode
	always @*
	begin
		analog_mask = analog_decode(conv_cfg_ff[`ANALOG_SEL_MSB:`ANALOG_SEL_LSB]);
		// Direction applies in both modes; latch held
		nxt_analog_out = analog_latch_ff;
		nxt_analog_oe = ~analog_dir_ff;
		nxt_led_out = led_latch_ff;
		nxt_led_oe = ~led_dir_ff;
		// Two-wire module owns pins 7 and 6
		if (twowire_en)
		begin
			nxt_led_out[7] = twowire_sda_out;
			nxt_led_oe[7] = twowire_sda_oe;
			nxt_led_out[6] = twowire_scl_out;
			nxt_led_oe[6] = twowire_scl_oe;
		end
		// Charge control bypasses latch and direction
		if (charge_en)
		begin
			nxt_led_out[0] = charge_dac_out;
			nxt_led_oe[0] = 1'b1;
			nxt_led_out[1] = charge_cmp_out;
			nxt_led_oe[1] = 1'b1;
		end
		// Pull-ups when bit clear and pin input
		nxt_pullup = {6{~option_ff[`PULLUP_DIS_BIT]}} & ~nxt_led_oe[5:0];
		// Only inputs compared; serial pins excluded
		monitor_en = led_dir_ff[7:4];
		if (twowire_en)
			monitor_en[3:2] = 2'b00;
		// Set wins over clear
		nxt_flag = change_flag_ff;
		if (flag_wr_clear)
			nxt_flag = 1'b0;
		if (mismatch)
			nxt_flag = 1'b1;
	end

	// Read mux and address decode
	always @*
	begin
		nxt_prdata = `ZERO_WORD;
		nxt_slverr = 1'b0;
		case (paddr)
			`ANALOG_PORT_DATA_ADDR: nxt_prdata = byte_word({4'h0, analog_digital_in});
			`ANALOG_PORT_DIR_ADDR: nxt_prdata = byte_word({4'h0, analog_dir_ff});
			`LED_PORT_DATA_ADDR: nxt_prdata = byte_word(led_sync);
			`LED_PORT_DIR_ADDR: nxt_prdata = byte_word(led_dir_ff);
			`CONV_CFG_ONE_ADDR: nxt_prdata = byte_word(conv_cfg_ff);
			`OPTION_ADDR: nxt_prdata = byte_word(option_ff);
			`IRQ_FLAG_ADDR: nxt_prdata = byte_word({7'h00, change_flag_ff});
			`IRQ_ENABLE_ADDR: nxt_prdata = byte_word(irq_en_ff);
			`CHARGE_CFG_ADDR: nxt_prdata = byte_word(charge_cfg_ff);
			`TWOWIRE_CTRL_ADDR: nxt_prdata = byte_word(twowire_ctrl_ff);
			default: nxt_slverr = 1'b1;
		endcase
	end

	// Register writes and registered outputs
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			analog_latch_ff <= {APORT_W{1'b0}};
			analog_dir_ff <= {APORT_W{1'b1}};
			led_latch_ff <= `ZERO_BYTE;
			led_dir_ff <= `DIR_RESET;
			conv_cfg_ff <= `CONV_CFG_RESET;
			option_ff <= `OPTION_RESET;
			irq_en_ff <= `ZERO_BYTE;
			charge_cfg_ff <= `ZERO_BYTE;
			twowire_ctrl_ff <= `ZERO_BYTE;
			change_flag_ff <= 1'b0;
			prdata <= `ZERO_WORD;
			pready <= 1'b0;
			pslverr <= 1'b0;
			analog_pin_out <= {APORT_W{1'b0}};
			analog_pin_oe <= {APORT_W{1'b0}};
			analog_sel_out <= {APORT_W{1'b0}};
			led_pin_out <= `ZERO_BYTE;
			led_pin_oe <= `ZERO_BYTE;
			led_pullup_en <= 6'h00;
			charge_dac_sel <= 1'b0;
			change_irq <= 1'b0;
			change_wake <= 1'b0;
		end
		else if (ce)
		begin
			// One wait state: answer in cycle after first access
			pready <= access && !pready;
			pslverr <= access && !pready && nxt_slverr;
			if (rd && !pready)
				prdata <= nxt_prdata;
			// Writes take effect at the completing edge
			if (wr && pready)
			begin
				case (paddr)
					`ANALOG_PORT_DATA_ADDR: analog_latch_ff <= pwdata[APORT_W-1:0];
					`ANALOG_PORT_DIR_ADDR: analog_dir_ff <= pwdata[APORT_W-1:0];
					`LED_PORT_DATA_ADDR: led_latch_ff <= pwdata[7:0];
					`LED_PORT_DIR_ADDR: led_dir_ff <= pwdata[7:0];
					`CONV_CFG_ONE_ADDR: conv_cfg_ff <= pwdata[7:0];
					`OPTION_ADDR: option_ff <= pwdata[7:0];
					`IRQ_ENABLE_ADDR: irq_en_ff <= pwdata[7:0];
					`CHARGE_CFG_ADDR: charge_cfg_ff <= pwdata[7:0];
					`TWOWIRE_CTRL_ADDR: twowire_ctrl_ff <= pwdata[7:0];
					default: ;
				endcase
			end
			change_flag_ff <= (wr && !pready) ? change_flag_ff | mismatch : nxt_flag;
			analog_pin_out <= nxt_analog_out;
			analog_pin_oe <= nxt_analog_oe;
			analog_sel_out <= analog_mask;
			led_pin_out <= nxt_led_out;
			led_pin_oe <= nxt_led_oe;
			led_pullup_en <= nxt_pullup;
			charge_dac_sel <= charge_en;
			// Interrupt and wake gated by enable
			change_irq <= nxt_flag && irq_en_ff[`CHANGE_EN_BIT];
			change_wake <= nxt_flag && irq_en_ff[`CHANGE_EN_BIT];
		end
	end
endmodule
`default_nettype wire

/* sim/io_ports_props.sv */
`timescale 1ns/100ps
`default_nettype none
`include "io_ports_regs.vh"
// Port-level checks of the I/O block
module io_ports_props #(
	parameter APORT_W = 4,
	parameter LPORT_W = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [APORT_W-1:0] analog_pin_oe,
	input wire logic [APORT_W-1:0] analog_sel_out,
	input wire logic [LPORT_W-1:0] led_pin_oe,
	input wire logic [5:0] led_pullup_en,
	input wire logic charge_dac_sel,
	input wire logic change_irq,
	input wire logic change_wake
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	apb_wait_a: assert property (psel && penable && !pready |=> pready) else $error("no ready");
	ready_pulse_a: assert property (pready |=> !pready) else $error("long ready");
	err_ready_a: assert property (pslverr |-> pready) else $error("lone error");
	analog_zero_a: assert property (pready && !pwrite && paddr == `ANALOG_PORT_DATA_ADDR
		|-> prdata[31:4] == 28'h000_0000 && (prdata[3:0] & analog_sel_out) == 4'h0) else $error("analog bits");
	pullup_out_a: assert property ((led_pullup_en & led_pin_oe[5:0]) == 6'h00) else $error("pull-up on");
	wake_irq_a: assert property (change_wake == change_irq) else $error("wake");
	charge_oe_a: assert property (charge_dac_sel && $past(charge_dac_sel) |-> led_pin_oe[1:0] == 2'b11)
		else $error("charge pins");
	reset_out_a: assert property ($rose(rst_n) |-> led_pin_oe == 8'h00 && led_pullup_en == 6'h00
		&& analog_pin_oe == 4'h0 ##1 analog_sel_out == 4'hf) else $error("reset state");
endmodule
bind mixed_signal_io_ports io_ports_props #(.APORT_W(APORT_W), .LPORT_W(LPORT_W)) u_props (.*);
`default_nettype wire

/* sim/board_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Board side of the pins
module board_model (
	input wire logic clk,
	input wire logic [7:0] led_pin_out,
	input wire logic [7:0] led_pin_oe,
	input wire logic [5:0] led_pullup_en,
	input wire logic [3:0] analog_pin_out,
	input wire logic [3:0] analog_pin_oe,
	input wire logic [7:0] ext_led,
	input wire logic [7:0] ext_en,
	input wire logic [3:0] ext_an,
	output logic [7:0] led_pin_in,
	output logic [3:0] analog_pin_in
);
	logic [7:0] last = 8'h00; // Last level, so a floating pin wanders
	always @(posedge clk)
		last <= led_pin_in;
	// Device driver first, then board, then pull-up, else float
	assign led_pin_in = (led_pin_oe & led_pin_out) | (~led_pin_oe & ((ext_en & ext_led)
		| (~ext_en & ({2'b00, led_pullup_en} | ~last))));
	assign analog_pin_in = (analog_pin_oe & analog_pin_out) | (~analog_pin_oe & ext_an);
endmodule
`default_nettype wire

/* sim/mixed_signal_io_ports_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "io_ports_regs.vh"
module mixed_signal_io_ports_tb;
	logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, r, seed = 32'hae2e;
	logic [3:0] pstrb = 4'h1, analog_pin_in, analog_pin_out, analog_pin_oe, analog_sel_out, ext_an = 4'h0;
	logic [7:0] led_pin_in, led_pin_out, led_pin_oe, ext_led = 8'h00, ext_en = 8'hff, lat, dir;
	logic [5:0] led_pullup_en;
	logic pready, pslverr, charge_dac_sel, change_irq, change_wake, charge_dac_out = 1'b1, charge_cmp_out = 1'b0;
	logic twowire_sda_out = 1'b0, twowire_sda_oe = 1'b0, twowire_scl_out = 1'b0, twowire_scl_oe = 1'b0;
	int mismatches = 0, total_checks = 0;
	mixed_signal_io_ports DUT (.*);
	board_model board (.*);
	always #4 clk = ~clk;
	// Xorshift source
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	// Digital pins per analog select code
	function automatic logic [3:0] dmask(input logic [1:0] c);
		return (c == 2'd3) ? 4'hf : (c == 2'd2) ? 4'hc : (c == 2'd1) ? 4'h8 : 4'h0;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One APB transfer, bounded wait on pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
		if (n == 20)
			mismatches++;
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 8'h00);
		chk(r, e);
	endtask
	// Write, then let pins settle
	task automatic wt(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
		repeat (4) @(posedge clk);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Watchdog
	initial
	begin
		#50000;
		mismatches++;
		summarize();
	end
	initial
	begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rd(`ANALOG_PORT_DIR_ADDR, 32'h0000_000f);
		rd(`LED_PORT_DIR_ADDR, 32'h0000_00ff);
		rd(`ANALOG_PORT_DATA_ADDR, 0);
		chk(led_pullup_en, 0);
		$display("reset test done");
		for (int i = 0; i < 4; i++)
		begin
			ext_an <= 4'(rnd());
			wt(`CONV_CFG_ONE_ADDR, 8'(i));
			chk(analog_sel_out, 4'(~dmask(2'(i))));
			rd(`ANALOG_PORT_DATA_ADDR, ext_an & dmask(2'(i)));
		end
		wt(`ANALOG_PORT_DATA_ADDR, 8'ha5);
		wt(`ANALOG_PORT_DIR_ADDR, 8'hf0);
		chk({analog_pin_oe, analog_pin_out}, 32'h0000_00f5);
		rd(`ANALOG_PORT_DATA_ADDR, 32'h0000_0005);
		rd(`ANALOG_PORT_DIR_ADDR, 0);
		wt(`CONV_CFG_ONE_ADDR, 8'h00);
		rd(`ANALOG_PORT_DATA_ADDR, 0);
		chk(analog_pin_oe, 32'h0000_000f);
		wt(`ANALOG_PORT_DIR_ADDR, 8'hff);
		$display("analog test done");
		wt(`OPTION_ADDR, 8'h7f);
		repeat (8)
		begin
			lat = rnd();
			dir = rnd();
			ext_led <= rnd();
			wt(`LED_PORT_DATA_ADDR, lat);
			wt(`LED_PORT_DIR_ADDR, dir);
			chk({led_pin_oe, 2'b00, led_pullup_en}, {~dir, 2'b00, dir[5:0]});
			rd(`LED_PORT_DATA_ADDR, (lat & ~dir) | (ext_led & dir));
		end
		wt(`LED_PORT_DIR_ADDR, 8'hff);
		ext_en <= 8'hc0;
		repeat (4) @(posedge clk);
		rd(`LED_PORT_DATA_ADDR, {ext_led[7:6], 6'h3f});
		ext_en <= 8'hff;
		wt(`OPTION_ADDR, 8'hff);
		chk(led_pullup_en, 0);
		$display("led test done");
		ext_led <= 8'h00;
		wt(`IRQ_ENABLE_ADDR, 8'h08);
		rd(`LED_PORT_DATA_ADDR, 0);
		wt(`IRQ_FLAG_ADDR, 8'h00);
		chk(change_irq, 0);
		ext_led <= 8'h10;
		repeat (4) @(posedge clk);
		chk(change_irq, 1);
		wt(`IRQ_FLAG_ADDR, 8'h00);
		chk(change_irq, 1);
		rd(`LED_PORT_DATA_ADDR, 32'h0000_0010);
		wt(`IRQ_FLAG_ADDR, 8'h00);
		chk(change_irq, 0);
		wt(`LED_PORT_DIR_ADDR, 8'hdf);
		wt(`LED_PORT_DATA_ADDR, 8'h20);
		ext_led <= 8'h18;
		repeat (4) @(posedge clk);
		chk(change_irq, 0);
		wt(`TWOWIRE_CTRL_ADDR, 8'h20);
		ext_led <= 8'hd8;
		repeat (4) @(posedge clk);
		chk(change_irq, 0);
		wt(`TWOWIRE_CTRL_ADDR, 8'h00);
		chk(change_irq, 1);
		wt(`IRQ_ENABLE_ADDR, 8'h00);
		chk(change_irq, 0);
		$display("change test done");
		wt(`CHARGE_CFG_ADDR, 8'h02);
		chk({charge_dac_sel, led_pin_oe[1:0], led_pin_out[1:0]}, 32'h0000_001d);
		apb(1'b0, 12'h0ff, 8'h00);
		chk({err, r[30:0]}, 32'h8000_0000);
		$display("charge and map test done");
		summarize();
	end
endmodule
`default_nettype wire
